// ==== src/usr8_pkg.sv ====
// constants shared by the universal shift/storage register
package usr8_pkg;

   // ----------------------------------------------------------------
   // datapath
   // ----------------------------------------------------------------
   localparam int unsigned USR8_WIDTH     = 8;
   localparam int unsigned USR8_WIDTH_MIN = 2;
   localparam int unsigned USR8_WIDTH_MAX = 16;

   // function select {high, low}
   typedef enum logic [1:0] {
      USR8_MODE_HOLD  = 2'b00,
      USR8_MODE_RIGHT = 2'b01,
      USR8_MODE_LEFT  = 2'b10,
      USR8_MODE_LOAD  = 2'b11
   } usr8_mode_t;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int unsigned USR8_ADDR_W        = 4;
   localparam logic [3:0]  USR8_OFS_CTRL      = 4'h0;
   localparam logic [3:0]  USR8_OFS_STATUS    = 4'h4;
   localparam logic [3:0]  USR8_OFS_EDGES     = 4'h8;

   // control fields
   localparam int unsigned USR8_CTRL_FREEZE   = 0;
   localparam int unsigned USR8_CTRL_SCLEAR   = 1;
   localparam logic        USR8_FREEZE_RST    = 1'b0;

   // status fields
   localparam int unsigned USR8_ST_DATA_LSB   = 0;
   localparam int unsigned USR8_ST_MODE_LSB   = 16;
   localparam int unsigned USR8_ST_DRIVE      = 18;
   localparam int unsigned USR8_ST_CLEAR      = 19;
   localparam int unsigned USR8_ST_FIRST      = 20;
   localparam int unsigned USR8_ST_LAST       = 21;

   // edge counter
   localparam int unsigned USR8_EDGE_CNT_W    = 16;
   localparam logic [15:0] USR8_EDGE_CNT_RST  = 16'h0000;

   // ahb-lite encodings
   localparam logic [1:0]  USR8_HTRANS_NONSEQ = 2'b10;
   localparam logic        USR8_HRESP_OKAY    = 1'b0;

   // synchroniser depth
   localparam int unsigned USR8_SYNC_STAGES   = 2;

endpackage

// ==== src/usr8_sync.sv ====
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module usr8_sync #(
   parameter int unsigned      WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] stable;

   // ----------------------------------------------------------------
   // first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta   <= RESET_VAL;
         stable <= RESET_VAL;
      end else begin
         meta   <= d_i;
         stable <= meta;
      end
   end

   assign q_o = stable;

endmodule

// ==== src/usr8_shift_reg.sv ====
// eight-bit universal shift/storage register with clear, three-state ports and ahb-lite view
//
// Overview of operation
// - eight flip-flop register, shiftable or storable, with clear and three-state ports
// - four modes only: hold, shift right, shift left, parallel load
// - two selects pick the mode; contents hold without a rising shift clock
// - both selects high loads in parallel on rising edge; outside drives ports
// - both selects high releases all port drivers regardless of output controls
// - in load each stage captures its own port level, outputs isolated
// - outside load, ports show contents whenever both output controls are low
// - clear low zeroes all stages and serial outputs, regardless of clock or mode
// - either output control high floats ports; register operation continues unchanged
// - right shift: first takes right input; left shift: last takes left input
// - serial outputs mirror first and last stages, ignoring output controls
`timescale 1ns/1ps
module usr8_shift_reg
   import usr8_pkg::*;
#(
   parameter int unsigned WIDTH = USR8_WIDTH
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // device pins
   input  wire logic             shift_clk_i,
   input  wire logic             func_select_low_i,
   input  wire logic             func_select_high_i,
   input  wire logic             port_disable_a_n_i,
   input  wire logic             port_disable_b_n_i,
   input  wire logic             direct_clear_n_i,
   input  wire logic             right_serial_in_i,
   input  wire logic             left_serial_in_i,
   input  wire logic [WIDTH-1:0] port_bits_i,
   output logic      [WIDTH-1:0] port_bits_o,
   output logic      [WIDTH-1:0] port_bits_oe_n_o,
   output logic                  first_stage_serial_out_o,
   output logic                  last_stage_serial_out_o,
   // ahb-lite slave
   input  wire logic             hsel_i,
   input  wire logic [31:0]      haddr_i,
   input  wire logic [1:0]       htrans_i,
   input  wire logic             hwrite_i,
   input  wire logic [2:0]       hsize_i,
   input  wire logic [31:0]      hwdata_i,
   input  wire logic             hready_i,
   output logic                  hreadyout_o,
   output logic                  hresp_o,
   output logic      [31:0]      hrdata_o
);

   // ----------------------------------------------------------------
   // elaboration check
   // ----------------------------------------------------------------
   if ((WIDTH < USR8_WIDTH_MIN) || (WIDTH > USR8_WIDTH_MAX)) begin : g_bad_width
      $error("usr8_shift_reg: WIDTH must lie between 2 and 16");
   end

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   localparam int unsigned SYNC_W = WIDTH + 8;
   localparam int unsigned P_SCLK = WIDTH + 7;
   localparam int unsigned P_SELH = WIDTH + 6;
   localparam int unsigned P_SELL = WIDTH + 5;
   localparam int unsigned P_DISA = WIDTH + 4;
   localparam int unsigned P_DISB = WIDTH + 3;
   localparam int unsigned P_CLRN = WIDTH + 2;
   localparam int unsigned P_SR   = WIDTH + 1;
   localparam int unsigned P_SL   = WIDTH;

   // disables and clear rest inactive so reset does not look like a pin event
   localparam logic [SYNC_W-1:0] SYNC_RST =
      SYNC_W'(({1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}) << WIDTH);

   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;

   assign pins_raw = {shift_clk_i, func_select_high_i, func_select_low_i,
                      port_disable_a_n_i, port_disable_b_n_i, direct_clear_n_i,
                      right_serial_in_i, left_serial_in_i, port_bits_i};

   usr8_sync #(
      .WIDTH     (SYNC_W),
      .RESET_VAL (SYNC_RST)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (pins_raw),
      .q_o   (pins_s)
   );

   logic             sclk_s;
   logic             sclk_prev;
   logic             sclk_rise;
   logic             dis_a_n_s;
   logic             dis_b_n_s;
   logic             clear_n_s;
   logic             sr_s;
   logic             sl_s;
   logic [WIDTH-1:0] port_s;
   usr8_mode_t       mode;

   assign sclk_s    = pins_s[P_SCLK];
   assign dis_a_n_s = pins_s[P_DISA];
   assign dis_b_n_s = pins_s[P_DISB];
   assign clear_n_s = pins_s[P_CLRN];
   assign sr_s      = pins_s[P_SR];
   assign sl_s      = pins_s[P_SL];
   assign port_s    = pins_s[WIDTH-1:0];
   assign mode      = usr8_mode_t'({pins_s[P_SELH], pins_s[P_SELL]});

   // ----------------------------------------------------------------
   // shift clock edge as a one-cycle enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= sclk_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_prev;

   // ----------------------------------------------------------------
   // control registers written by software
   // ----------------------------------------------------------------
   logic freeze;
   logic soft_clear;
   logic clear_act;
   logic step;

   assign clear_act = ~clear_n_s | soft_clear;
   assign step      = sclk_rise & ~freeze;

   // ----------------------------------------------------------------
   // next-stage neighbours, one per bit
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] stage;
   logic [WIDTH-1:0] from_prev;
   logic [WIDTH-1:0] from_next;
   logic [WIDTH-1:0] next_stage;

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      if (i == 0) begin : g_first
         assign from_prev[i] = sr_s;
      end else begin : g_prev
         assign from_prev[i] = stage[i-1];
      end
      if (i == WIDTH - 1) begin : g_last
         assign from_next[i] = sl_s;
      end else begin : g_next
         assign from_next[i] = stage[i+1];
      end
   end

   always_comb begin
      case (mode)
         USR8_MODE_HOLD:  next_stage = stage;
         USR8_MODE_RIGHT: next_stage = from_prev;
         USR8_MODE_LEFT:  next_stage = from_next;
         USR8_MODE_LOAD:  next_stage = port_s;
         default:         next_stage = stage;
      endcase
   end

   // ----------------------------------------------------------------
   // storage flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stage <= '0;
      end else if (clear_act) begin
         stage <= '0;
      end else if (step) begin
         stage <= next_stage;
      end
   end

   // ----------------------------------------------------------------
   // parallel ports and serial outputs
   // ----------------------------------------------------------------
   logic drive_ports;

   // load isolates the stages from the ports; either control high floats them
   assign drive_ports = dis_a_n_s == 1'b0 && dis_b_n_s == 1'b0
                        && mode != USR8_MODE_LOAD;

   assign port_bits_o              = stage;
   assign port_bits_oe_n_o         = {WIDTH{~drive_ports}};
   assign first_stage_serial_out_o = stage[0];
   assign last_stage_serial_out_o  = stage[WIDTH-1];

   // ----------------------------------------------------------------
   // accepted edge counter
   // ----------------------------------------------------------------
   logic [USR8_EDGE_CNT_W-1:0] edge_cnt;
   logic                       edge_cnt_clr;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         edge_cnt <= USR8_EDGE_CNT_RST;
      end else if (step && !clear_act) begin
         // an edge counted in the same cycle as a counter clear restarts the count at one
         edge_cnt <= edge_cnt_clr ? USR8_EDGE_CNT_W'(1) : edge_cnt + USR8_EDGE_CNT_W'(1);
      end else if (edge_cnt_clr) begin
         edge_cnt <= USR8_EDGE_CNT_RST;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite address phase
   // ----------------------------------------------------------------
   logic                   acc;
   logic                   wr_pend;
   logic [USR8_ADDR_W-1:0] wr_addr;
   logic [31:0]            status_word;
   logic [31:0]            next_rdata;

   assign acc = hsel_i & hready_i & (htrans_i == USR8_HTRANS_NONSEQ);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
      end else begin
         wr_pend <= acc & hwrite_i & (haddr_i[31:USR8_ADDR_W] == '0);
         wr_addr <= haddr_i[USR8_ADDR_W-1:0];
      end
   end

   always_comb begin
      status_word                                        = '0;
      status_word[USR8_ST_DATA_LSB +: WIDTH]             = stage;
      status_word[USR8_ST_MODE_LSB +: 2]                 = mode;
      status_word[USR8_ST_DRIVE]                         = drive_ports;
      status_word[USR8_ST_CLEAR]                         = clear_act;
      status_word[USR8_ST_FIRST]                         = stage[0];
      status_word[USR8_ST_LAST]                          = stage[WIDTH-1];
   end

   always_comb begin
      next_rdata = '0;
      if (haddr_i[31:USR8_ADDR_W] == '0) begin
         case (haddr_i[USR8_ADDR_W-1:0])
            USR8_OFS_CTRL:   next_rdata[USR8_CTRL_FREEZE] = freeze;
            USR8_OFS_STATUS: next_rdata = status_word;
            USR8_OFS_EDGES:  next_rdata[USR8_EDGE_CNT_W-1:0] = edge_cnt;
            default:         next_rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hrdata_o <= '0;
      end else if (acc && !hwrite_i) begin
         hrdata_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // ahb-lite data phase writes
   // ----------------------------------------------------------------
   logic ctrl_wr;

   assign ctrl_wr      = wr_pend && wr_addr == USR8_OFS_CTRL;
   assign edge_cnt_clr = wr_pend && wr_addr == USR8_OFS_EDGES;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         freeze <= USR8_FREEZE_RST;
      end else if (ctrl_wr) begin
         freeze <= hwdata_i[USR8_CTRL_FREEZE];
      end
   end

   // soft clear lasts one cycle after the write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_clear <= 1'b0;
      end else begin
         soft_clear <= ctrl_wr & hwdata_i[USR8_CTRL_SCLEAR];
      end
   end

   // zero wait states, always okay
   assign hreadyout_o = 1'b1;
   assign hresp_o     = USR8_HRESP_OKAY;

   // hsize is ignored; narrower writes act as word writes
   logic unused_hsize;
   assign unused_hsize = ^hsize_i;

endmodule

// ==== dv/usr8_shift_reg_properties.sv ====
// concurrent checks on the shift register pins
`timescale 1ns/1ps
module usr8_props
   import usr8_pkg::*;
#(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             shift_clk_i,
   input  wire logic             func_select_low_i,
   input  wire logic             func_select_high_i,
   input  wire logic             port_disable_a_n_i,
   input  wire logic             port_disable_b_n_i,
   input  wire logic             direct_clear_n_i,
   input  wire logic             right_serial_in_i,
   input  wire logic             left_serial_in_i,
   input  wire logic [WIDTH-1:0] port_bits_i,
   input  wire logic [WIDTH-1:0] port_bits_o,
   input  wire logic [WIDTH-1:0] port_bits_oe_n_o,
   input  wire logic             first_stage_serial_out_o,
   input  wire logic             last_stage_serial_out_o,
   input  wire logic             hsel_i,
   input  wire logic [1:0]       htrans_i,
   input  wire logic             hwrite_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire sel_ld = func_select_high_i && func_select_low_i;
   wire bus_wr = hsel_i && hwrite_i && htrans_i == USR8_HTRANS_NONSEQ;
   // one shift clock edge with the mode held
   sequence step_s(logic hi, logic lo);
      !shift_clk_i ##1 (shift_clk_i && func_select_high_i == hi && func_select_low_i == lo
         && direct_clear_n_i && $stable(right_serial_in_i) && $stable(left_serial_in_i))[*4];
   endsequence
   load_float_a:
      assert property (sel_ld [*3] |-> &port_bits_oe_n_o) else $error("ports driven in load");
   read_drive_a:
      assert property ((!sel_ld && !port_disable_a_n_i && !port_disable_b_n_i) [*3]
         |-> port_bits_oe_n_o == '0) else $error("ports not driven");
   ctrl_float_a:
      assert property ((port_disable_a_n_i || port_disable_b_n_i) [*3]
         |-> &port_bits_oe_n_o) else $error("ports driven while disabled");
   clear_zero_a:
      assert property (!direct_clear_n_i [*4] |=> port_bits_o == '0
         && !first_stage_serial_out_o && !last_stage_serial_out_o) else $error("clear missed");
   mirror_out_a:
      assert property (first_stage_serial_out_o == port_bits_o[0]
         && last_stage_serial_out_o == port_bits_o[WIDTH-1]) else $error("serial out wrong");
   hold_keep_a:
      assert property ((!shift_clk_i && direct_clear_n_i && !bus_wr) [*4]
         |=> $stable(port_bits_o)) else $error("contents moved without edge");
   hold_step_a:
      assert property (step_s(1'b0, 1'b0) |-> port_bits_o == $past(port_bits_o, 2))
         else $error("hold moved");
   right_step_a:
      assert property (step_s(1'b0, 1'b1) |-> port_bits_o == (($past(port_bits_o, 2) << 1)
         | $past(right_serial_in_i, 2))) else $error("right shift wrong");
   left_step_a:
      assert property (step_s(1'b1, 1'b0) |-> port_bits_o == (($past(port_bits_o, 2) >> 1)
         | (WIDTH'($past(left_serial_in_i, 2)) << (WIDTH-1)))) else $error("left shift wrong");
   load_step_a:
      assert property (step_s(1'b1, 1'b1) |-> port_bits_o == $past(port_bits_i, 3))
         else $error("load wrong");
endmodule

bind usr8_shift_reg usr8_props #(.WIDTH(WIDTH)) u_usr8_props (.*);

// ==== dv/usr8_bus_model.sv ====
// far side of the parallel ports: outside driver and floating lines
`timescale 1ns/1ps
module usr8_bus_model #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic [WIDTH-1:0] dev_bits_i,
   input  wire logic [WIDTH-1:0] dev_oe_n_i,
   input  wire logic             drv_en_i,
   input  wire logic [WIDTH-1:0] drv_bits_i,
   output logic      [WIDTH-1:0] bus_o
);
   logic [WIDTH-1:0] last = '0;
   // a floating line flips every cycle so it never looks like data
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         if (!dev_oe_n_i[i]) bus_o[i] = dev_bits_i[i];
         else if (drv_en_i) bus_o[i] = drv_bits_i[i];
         else bus_o[i] = ~last[i];
      end
   end
   always_ff @(posedge clk_i) begin
      last <= bus_o;
   end
endmodule

// ==== dv/usr8_shift_reg_bench.sv ====
// self-checking bench for the shift register
`timescale 1ns/1ps
module usr8_shift_reg_bench
   import usr8_pkg::*;
;
   logic        clk_i = 0, rst_i = 1, sclk = 0, fsl = 0, fsh = 0, da_n = 0, db_n = 0;
   logic        clr_n = 1, rin = 0, lin = 0, drv_en = 0, hsel = 0, hwrite = 0;
   logic        pin_look = 0, rd_look = 0, fso, lso, hro, hrs;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrd;
   logic [7:0]  drv = 8'h00, st = 8'h00, bus, pbo, oen;
   logic [32:0] exp_q[$];
   int          err_count = 0, n_tests = 0, seed = 32'h68fbb4c1;
   always #5 clk_i = ~clk_i;
   usr8_shift_reg u_usr8_shift_reg (.clk_i(clk_i), .rst_i(rst_i), .shift_clk_i(sclk),
      .func_select_low_i(fsl), .func_select_high_i(fsh), .port_disable_a_n_i(da_n),
      .port_disable_b_n_i(db_n), .direct_clear_n_i(clr_n), .right_serial_in_i(rin),
      .left_serial_in_i(lin), .port_bits_i(bus), .port_bits_o(pbo), .port_bits_oe_n_o(oen),
      .first_stage_serial_out_o(fso), .last_stage_serial_out_o(lso), .hsel_i(hsel),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hro), .hreadyout_o(hro), .hresp_o(hrs), .hrdata_o(hrd));
   usr8_bus_model u_usr8_bus_model (.clk_i(clk_i), .dev_bits_i(pbo), .dev_oe_n_i(oen),
      .drv_en_i(drv_en), .drv_bits_i(drv), .bus_o(bus));
   // ------------------------------------------------------------
   // monitor: oldest note against what the outputs show
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      logic [32:0] e, o;
      if (pin_look === 1'b1 || (rd_look === 1'b1 && hro === 1'b1)) begin
         e = exp_q.pop_front();
         o = rd_look ? {~hrs, hrd} : {9'h0, oen, 6'h0, fso, lso, pbo};
         n_tests++;
         if (o !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, o, e);
         end
      end
   end
   task automatic results();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic pin_chk(input logic f);
      exp_q.push_back({9'h0, {8{f}}, 6'h0, st[0], st[7], st});
      pin_look <= 1'b1;
      @(posedge clk_i);
      pin_look <= 1'b0;
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= USR8_HTRANS_NONSEQ;
      hsel <= 1'b1;
      do @(posedge clk_i); while (hro !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      if (!wr) exp_q.push_back({1'b1, d});
      rd_look <= !wr;
      do @(posedge clk_i); while (hro !== 1'b1);
      rd_look <= 1'b0;
   endtask
   // one shift clock pulse with random serial ins, data and output controls
   task automatic step(input logic [1:0] m);
      logic [7:0] d;
      logic       r, l, a, b;
      {d, r, l, a, b} = 12'($random(seed));
      {fsh, fsl} <= m;
      {rin, lin, da_n, db_n, drv} <= {r, l, a, b, d};
      drv_en <= (m == USR8_MODE_LOAD);
      repeat (3) @(posedge clk_i);
      sclk <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (clr_n !== 1'b1) st = 8'h00;
      else if (m == USR8_MODE_RIGHT) st = {st[6:0], r};
      else if (m == USR8_MODE_LEFT) st = {l, st[7:1]};
      else if (m == USR8_MODE_LOAD) st = d;
      pin_chk(m == USR8_MODE_LOAD || a || b);
   endtask
   initial begin
      #20us;
      err_count++;
      results();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      pin_chk(1'b0);
      for (int i = 0; i < 24; i++) begin
         step(i < 4 ? 2'(i) : 2'($random(seed)));
      end
      {fsh, fsl, da_n, db_n} <= 4'h0;
      repeat (3) @(posedge clk_i);
      ahb(1'b0, 32'(USR8_OFS_STATUS), 32'(st) | 32'h1 << USR8_ST_DRIVE
         | 32'(st[0]) << USR8_ST_FIRST | 32'(st[7]) << USR8_ST_LAST);
      ahb(1'b0, 32'(USR8_OFS_EDGES), 32'd24);
      ahb(1'b1, 32'(USR8_OFS_EDGES), 32'h0);
      ahb(1'b0, 32'(USR8_OFS_EDGES), 32'h0);
      ahb(1'b1, 32'(USR8_OFS_CTRL), 32'h1 << USR8_CTRL_FREEZE);
      ahb(1'b0, 32'(USR8_OFS_CTRL), 32'h1);
      ahb(1'b1, 32'(USR8_OFS_CTRL), 32'h1 << USR8_CTRL_SCLEAR);
      ahb(1'b0, 32'(USR8_OFS_CTRL), 32'h0);
      st = 8'h00;
      pin_chk(1'b0);
      ahb(1'b1, 32'h10, 32'hffffffff);
      ahb(1'b0, 32'h10, 32'h0);
      clr_n <= 1'b0;
      repeat (5) @(posedge clk_i);
      step(USR8_MODE_LOAD);
      clr_n <= 1'b1;
      repeat (3) @(posedge clk_i);
      step(USR8_MODE_LEFT);
      results();
   end
endmodule
